// ### logic/lss_ctrl.v
// serial control and fault report front end of a sixteen-output low-side switch
`timescale 1ns/1ps
`include "lss_consts.vh"
module lss_ctrl (
   input wire core_clk, // 200 MHz clock
   input wire rst_b, // hardware reset pin, active low
   input wire clk_en, // freezes all state when low
   input wire sop_ok, // serial-out supply above 2.5 V
   input wire sclk, // serial clock from master
   input wire cs_b, // chip select, active low
   input wire si, // serial data in
   output reg so_o, // serial data out value
   output reg so_oe, // serial out driven when high
   input wire ov_det, // battery_supply over-voltage comparator
   input wire [15:0] therm_det, // per-output over-temperature
   input wire [15:0] ocur_det, // per-output over-current/short to supply
   input wire [15:0] open_det, // per-output open load
   output reg [15:0] low_side_outputs, // output driver gates
   output reg [15:0] open_cur_en, // open-load pull-down enables
   output reg [15:0] sfpd_r, // short fault protect disable bits
   output reg [15:0] pwm_en_r, // pwm enable bits
   output reg [15:0] and_or_r, // pwm and/or select
   output reg ov_shut // over-voltage shutdown active
);
   localparam W = `LSS_WORD_W;
   // three-stage pin synchronisers; change counted when stages 2 and 3 agree
   reg [2:0] sclk_s_r;
   reg [2:0] cs_s_r;
   reg [2:0] si_s_r;
   reg [2:0] ov_s_r;
   reg [2:0] sop_s_r;
   reg sclk_f_r;
   reg cs_f_r;
   reg ov_f_r;
   reg sop_f_r;
   wire sclk_stable = (sclk_s_r[1] == sclk_s_r[2]);
   wire cs_stable = (cs_s_r[1] == cs_s_r[2]);
   wire sclk_rise = sclk_stable && sclk_s_r[2] && !sclk_f_r;
   wire sclk_fall = sclk_stable && !sclk_s_r[2] && sclk_f_r;
   wire cs_fall = cs_stable && !cs_s_r[2] && cs_f_r;
   wire cs_rise = cs_stable && cs_s_r[2] && !cs_f_r;
   wire ov_f_nxt = (ov_s_r[1] == ov_s_r[2]) ? ov_s_r[2] : ov_f_r;
   wire sop_f_nxt = (sop_s_r[1] == sop_s_r[2]) ? sop_s_r[2] : sop_f_r;
   wire int_rst = !sop_f_r;
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclk_s_r <= 3'h0;
         // idle high, so leaving reset shows no false select edge
         cs_s_r <= 3'h7;
         si_s_r <= 3'h0;
         ov_s_r <= 3'h0;
         sop_s_r <= 3'h0;
         sclk_f_r <= 1'b0;
         cs_f_r <= 1'b1;
         ov_f_r <= 1'b0;
         sop_f_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sclk_s_r <= {sclk_s_r[1:0], sclk};
         cs_s_r <= {cs_s_r[1:0], cs_b};
         si_s_r <= {si_s_r[1:0], si};
         ov_s_r <= {ov_s_r[1:0], ov_det};
         sop_s_r <= {sop_s_r[1:0], sop_ok};
         if (sclk_stable)
            sclk_f_r <= sclk_s_r[2];
         if (cs_stable)
            cs_f_r <= cs_s_r[2];
         ov_f_r <= ov_f_nxt;
         sop_f_r <= sop_f_nxt;
      end
   end
   // serial shifters and frame bookkeeping
   reg [W-1:0] in_sr_r;
   reg [W-1:0] out_sr_r;
   reg [`LSS_CNT_W-1:0] bit_cnt_r;
   reg active_r;
   reg sclk_seen_r;
   reg ov_flag_r;
   reg [15:0] flt_r;
   reg [W-1:0] status_word;
   always @*
   begin
      status_word = {W{1'b0}};
      status_word[`LSS_BIT_ANY] = ov_flag_r | (|flt_r);
      status_word[`LSS_BIT_OV] = ov_flag_r;
      status_word[`LSS_OUT_N-1:0] = flt_r;
   end
   wire fifo_in_ready;
   wire word_end = (bit_cnt_r == 5'h17);
   // a frame with no clock at all would otherwise replay the stale input word
   wire frame_ok = active_r && sclk_seen_r && (bit_cnt_r == 5'h00);
   wire op_known = (in_sr_r[`LSS_OP_HI:`LSS_OP_LO] <= `LSS_OP_RESET);
   wire push = cs_rise && frame_ok && op_known && fifo_in_ready;
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         in_sr_r <= 24'h000000;
         out_sr_r <= 24'h000000;
         bit_cnt_r <= 5'h00;
         active_r <= 1'b0;
         so_o <= 1'b0;
         so_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         if (int_rst)
         begin
            in_sr_r <= 24'h000000;
            out_sr_r <= 24'h000000;
            bit_cnt_r <= 5'h00;
            active_r <= 1'b0;
            so_o <= 1'b0;
            so_oe <= 1'b0;
         end
         else if (cs_fall)
         begin
            // whole word loads; each rising edge after the first then exposes the next bit
            out_sr_r <= status_word;
            so_o <= status_word[W-1];
            so_oe <= 1'b1;
            bit_cnt_r <= 5'h00;
            active_r <= 1'b1;
         end
         else if (cs_rise)
         begin
            so_oe <= 1'b0;
            // park the data low while the pin is released
            so_o <= 1'b0;
            active_r <= 1'b0;
         end
         else if (active_r)
         begin
            if (sclk_fall)
            begin
               in_sr_r <= {in_sr_r[W-2:0], si_s_r[2]};
               // count modulo 24 so daisy chains of several words still latch
               if (word_end)
                  bit_cnt_r <= 5'h00;
               else
                  bit_cnt_r <= bit_cnt_r + 5'h01;
               // input bit follows output so chained words pass through intact
               out_sr_r <= {out_sr_r[W-2:0], si_s_r[2]};
            end
            // bit 23 already shows from select, so the first rise must not advance
            if (sclk_rise && sclk_seen_r)
            begin
               so_o <= out_sr_r[W-1];
            end
         end
      end
   end
   // first rising edge of a frame already shows bit 23, later ones advance
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         sclk_seen_r <= 1'b0;
      else if (clk_en)
      begin
         if (cs_fall || int_rst)
            sclk_seen_r <= 1'b0;
         else if (active_r && sclk_fall)
            sclk_seen_r <= 1'b1;
      end
   end
   // completed words queue for the control stage
   wire fifo_valid;
   wire [W-1:0] cmd;
   // the control stage takes a word every cycle, so the queue only absorbs bursts
   wire fifo_pop = fifo_valid;
   lss_fifo #(
      .WIDTH(W),
      .DEPTH(`LSS_FIFO_DEPTH),
      .AW(`LSS_FIFO_AW)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(in_sr_r),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(cmd)
   );
   // over-voltage filter
   reg [`LSS_OV_CNT_W-1:0] ov_cnt_r;
   reg [15:0] on_cmd_r;
   reg [15:0] latched_off_r;
   reg therm_retry_r;
   reg ov_recover_r;
   wire [5:0] opcode = cmd[`LSS_OP_HI:`LSS_OP_LO];
   wire ov_done = (ov_cnt_r == `LSS_OV_FILT_CYC);
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         ov_cnt_r <= 14'h0000;
      else if (clk_en)
      begin
         if (!ov_f_r || int_rst)
            ov_cnt_r <= 14'h0000;
         // holds at the filter figure so a long surge cannot wrap
         else if (!ov_done)
            ov_cnt_r <= ov_cnt_r + 14'h0001;
      end
   end
   // control registers, faults and drivers
   wire ov_nxt = ov_f_r && ov_done;
   // cycle in which the supply comes back; recovery bit decides the commands
   wire ov_leave = ov_shut && !ov_nxt;
   wire hit_reset = fifo_pop && (opcode == `LSS_OP_RESET);
   wire status_read = cs_fall && !int_rst;
   genvar g;
   generate
      for (g = 0; g < `LSS_OUT_N; g = g + 1)
      begin : g_out
         wire thermal = therm_det[g];
         wire open_rep = open_det[g] && !on_cmd_r[g] && open_cur_en[g];
         wire flt_now = thermal || ocur_det[g] || open_rep;
         // an output is switched off only by its command, its own thermal detector or a global shutdown
         wire drive_ok = on_cmd_r[g] && !thermal && !latched_off_r[g]
            && !ov_shut;
         always @(posedge core_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               flt_r[g] <= 1'b0;
               latched_off_r[g] <= 1'b0;
               low_side_outputs[g] <= 1'b0;
            end
            else if (clk_en)
            begin
               if (int_rst || hit_reset)
               begin
                  flt_r[g] <= 1'b0;
                  latched_off_r[g] <= 1'b0;
                  low_side_outputs[g] <= 1'b0;
               end
               else
               begin
                  // live fault wins over the clear on a status read
                  if (flt_now)
                     flt_r[g] <= 1'b1;
                  else if (status_read)
                     flt_r[g] <= 1'b0;
                  if (thermal && !therm_retry_r)
                     latched_off_r[g] <= 1'b1;
                  else if (fifo_pop && opcode == `LSS_OP_ONOFF)
                     latched_off_r[g] <= 1'b0;
                  low_side_outputs[g] <= drive_ok;
               end
            end
         end
      end
   endgenerate
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         on_cmd_r <= 16'h0000;
         open_cur_en <= 16'h0000;
         sfpd_r <= 16'h0000;
         pwm_en_r <= 16'h0000;
         and_or_r <= 16'h0000;
         therm_retry_r <= 1'b0;
         ov_recover_r <= 1'b0;
         ov_shut <= 1'b0;
         ov_flag_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (int_rst || hit_reset)
         begin
            on_cmd_r <= 16'h0000;
            open_cur_en <= 16'h0000;
            sfpd_r <= 16'h0000;
            pwm_en_r <= 16'h0000;
            and_or_r <= 16'h0000;
            therm_retry_r <= 1'b0;
            ov_recover_r <= 1'b0;
            ov_shut <= 1'b0;
            ov_flag_r <= 1'b0;
         end
         else
         begin
            ov_shut <= ov_nxt;
            if (ov_nxt)
               ov_flag_r <= 1'b1;
            else if (status_read)
               ov_flag_r <= 1'b0;
            if (ov_leave && !ov_recover_r)
               on_cmd_r <= 16'h0000;
            else if (fifo_pop)
            begin
               case (opcode)
                  `LSS_OP_ONOFF: on_cmd_r <= cmd[15:0];
                  `LSS_OP_OPENLD: open_cur_en <= cmd[15:0];
                  `LSS_OP_RETRY:
                  begin
                     therm_retry_r <= cmd[`LSS_BIT_THERM];
                     ov_recover_r <= cmd[`LSS_BIT_OVREC];
                  end
                  `LSS_OP_SFPD: sfpd_r <= cmd[15:0];
                  `LSS_OP_PWMEN: pwm_en_r <= cmd[15:0];
                  `LSS_OP_ANDOR: and_or_r <= cmd[15:0];
                  default: ;
               endcase
            end
         end
      end
   end
endmodule

// ### pkg/lss_consts.vh
// constants for the low-side switch serial control block
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH
`define LSS_WORD_W 24
`define LSS_OUT_N 16
`define LSS_CNT_W 5
`define LSS_OP_HI 23
`define LSS_OP_LO 18
`define LSS_BIT_THERM 17
`define LSS_BIT_OVREC 16
`define LSS_BIT_ANY 23
`define LSS_BIT_OV 22
`define LSS_OP_ONOFF 6'h00
`define LSS_OP_OPENLD 6'h01
`define LSS_OP_RETRY 6'h02
`define LSS_OP_SFPD 6'h03
`define LSS_OP_PWMEN 6'h04
`define LSS_OP_ANDOR 6'h05
`define LSS_OP_RESET 6'h06
`define LSS_OV_FILT_NS 50000
`define LSS_CLK_NS 5
`define LSS_OV_FILT_CYC ((`LSS_OV_FILT_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)
`define LSS_OV_CNT_W 14
`define LSS_FIFO_DEPTH 32
`define LSS_FIFO_AW 5
`endif

// ### logic/lss_fifo.v
// command word fifo between the serial front end and the control logic
`timescale 1ns/1ps
module lss_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire core_clk, // clock
   input wire rst_b, // async reset, active low
   input wire clk_en, // freeze when low
   input wire in_valid, // write request
   output wire in_ready, // space available
   input wire [WIDTH-1:0] in_data, // write data
   output wire out_valid, // data available
   input wire out_ready, // read accept
   output wire [WIDTH-1:0] out_data // head word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr_r;
   reg [AW:0] rd_ptr_r;
   wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   wire empty = (wr_ptr_r == rd_ptr_r);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_r[AW-1:0]];
   always @(posedge core_clk)
   begin
      if (clk_en && in_valid && !full)
         mem[wr_ptr_r[AW-1:0]] <= in_data;
   end
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_r <= {(AW+1){1'b0}};
         rd_ptr_r <= {(AW+1){1'b0}};
      end
      else if (clk_en)
      begin
         if (in_valid && !full)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (out_ready && !empty)
            rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule

// ### verif/lss_ctrl_monitor.sv
// assertion checker bound to the serial control block
`timescale 1ns/1ps
module lss_ctrl_monitor (
   input wire core_clk, // clock
   input wire rst_b, // reset, active low
   input wire sop_ok, // serial-out supply good
   input wire cs_b, // chip select, active low
   input wire so_oe, // serial out enable
   input wire ov_det, // over-voltage comparator
   input wire [15:0] therm_det, // over-temperature
   input wire [15:0] low_side_outputs, // driver gates
   input wire ov_shut // over-voltage shutdown
);
   reg [13:0] ov_cnt_r;
   // saturates so a long fault never wraps back under the filter figure
   always @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         ov_cnt_r <= 14'h0000;
      else if (!ov_det)
         ov_cnt_r <= 14'h0000;
      else if (ov_cnt_r != 14'h3FFF)
         ov_cnt_r <= ov_cnt_r + 14'h0001;
   reg [3:0] hold_cnt_r;
   wire hold_cond = !cs_b && sop_ok && !ov_shut && therm_det == 16'h0000;
   // consecutive settled selected cycles, saturating above the window
   always @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         hold_cnt_r <= 4'h0;
      else if (!hold_cond)
         hold_cnt_r <= 4'h0;
      else if (hold_cnt_r != 4'hF)
         hold_cnt_r <= hold_cnt_r + 4'h1;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   AST_RST_OFF:
      assert property ($rose(rst_b) |-> low_side_outputs == 16'h0000 && !ov_shut)
      else $error("outputs not off after reset");
   AST_SO_RELEASE:
      assert property (cs_b [*8] |-> !so_oe)
      else $error("serial out driven while deselected");
   AST_SO_DRIVE:
      assert property ((!cs_b && sop_ok) [*8] |-> so_oe)
      else $error("serial out not driven while selected");
   AST_SUPPLY_OFF:
      assert property (!sop_ok [*6] |-> low_side_outputs == 16'h0000)
      else $error("outputs on with low serial-out supply");
   AST_OV_FILTER:
      assert property ($rose(ov_shut) |-> ov_cnt_r >= 14'h2710)
      else $error("over-voltage shutdown before filter time");
   AST_OV_LATE:
      assert property (ov_cnt_r == 14'h2724 |-> ov_shut)
      else $error("over-voltage shutdown missing after filter time");
   AST_OV_OFF:
      assert property (ov_shut [*3] |-> low_side_outputs == 16'h0000)
      else $error("outputs on during over-voltage shutdown");
   AST_OV_CLEAR:
      assert property (!ov_det [*8] |-> !ov_shut)
      else $error("over-voltage shutdown held after condition cleared");
   AST_HOLD:
      assert property (hold_cond && hold_cnt_r >= 4'hB |-> $stable(low_side_outputs))
      else $error("outputs changed while selected");
   AST_THERM_OFF:
      assert property ($stable(therm_det) [*8] |-> (low_side_outputs & therm_det) == 16'h0000)
      else $error("overheated output still on");
   COV_OV: cover property ($rose(ov_shut));
   COV_FRAME: cover property ($rose(cs_b));
   COV_THERM: cover property (therm_det != 16'h0000);
endmodule
bind lss_ctrl lss_ctrl_monitor mon (.core_clk(core_clk), .rst_b(rst_b), .sop_ok(sop_ok),
   .cs_b(cs_b), .so_oe(so_oe), .ov_det(ov_det), .therm_det(therm_det),
   .low_side_outputs(low_side_outputs), .ov_shut(ov_shut));

// ### verif/lss_spi_master.sv
// serial master model driving the switch's serial pins
`timescale 1ns/1ps
module lss_spi_master (
   output logic sclk, // serial clock
   output logic cs_b, // chip select, active low
   output logic si, // serial data to device
   input wire so_o, // device serial out value
   input wire so_oe // device serial out enable
);
   logic last_so;
   wire so_line;
   // released line shows inverse of last bit so stale data never passes
   assign so_line = so_oe ? so_o : ~last_so;
   initial
   begin
      sclk = 1'b0;
      cs_b = 1'b1;
      si = 1'b0;
      last_so = 1'b0;
   end
   task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] r);
      r = 48'h0;
      cs_b = 1'b0; // clock low at both select edges
      #200;
      for (int i = n - 1; i >= 0; i--)
      begin
         #42 si = w[i]; // msb first
         #42 sclk = 1'b1; // 168 ns period, under 6 MHz
         #84 r = {r[46:0], so_line};
         last_so = so_line;
         sclk = 1'b0; // data changed away from the fall
      end
      #100 cs_b = 1'b1;
      si = 1'b0; // input has a pull-down
      #300;
   endtask
endmodule

// ### verif/tb.sv
// self-checking bench for the low-side switch serial control block
`timescale 1ns/1ps
module tb;
   logic core_clk, rst_b, sop_ok, ov_det;
   logic [15:0] therm_det, ocur_det, open_det;
   wire sclk, cs_b, si, so_o, so_oe, ov_shut;
   wire [15:0] outs, open_cur_en, sfpd_r, pwm_en_r, and_or_r;
   logic [47:0] rep;
   int err_count, n_tests;
   lss_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .sop_ok(sop_ok),
      .sclk(sclk), .cs_b(cs_b), .si(si), .so_o(so_o), .so_oe(so_oe), .ov_det(ov_det),
      .therm_det(therm_det), .ocur_det(ocur_det), .open_det(open_det),
      .low_side_outputs(outs), .open_cur_en(open_cur_en), .sfpd_r(sfpd_r),
      .pwm_en_r(pwm_en_r), .and_or_r(and_or_r), .ov_shut(ov_shut));
   lss_spi_master m (.sclk(sclk), .cs_b(cs_b), .si(si), .so_o(so_o), .so_oe(so_oe));
   task wait_clk(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task cmd(input logic [5:0] op, input logic [17:0] v);
      m.xfer({24'h000000, op, v}, 24, rep);
      wait_clk(20);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial
   begin
      #400000;
      err_count++;
      end_sim;
   end
   initial
   begin
      rst_b = 1'b0;
      sop_ok = 1'b1;
      ov_det = 1'b0;
      therm_det = 16'h0000;
      ocur_det = 16'h0000;
      open_det = 16'h0000;
      err_count = 0;
      n_tests = 0;
      wait_clk(8);
      rst_b = 1'b1;
      wait_clk(20);
      chk("rst outs", {8'h00, outs}, 24'h000000);
      chk("idle oe", {23'h0, so_oe}, 24'h000000);
      cmd(6'h00, 18'h0A5C3);
      chk("on", {8'h00, outs}, 24'h00A5C3);
      chk("clean reply", rep[23:0], 24'h000000);
      cmd(6'h3F, 18'h00000);
      m.xfer(48'h0, 23, rep);
      wait_clk(20);
      m.xfer(48'h0, 0, rep);
      wait_clk(20);
      chk("ignored", {8'h00, outs}, 24'h00A5C3);
      m.xfer(48'h00123400FFFF, 48, rep);
      wait_clk(20);
      chk("chain latch", {8'h00, outs}, 24'h00FFFF);
      chk("chain echo", rep[23:0], 24'h001234);
      cmd(6'h01, 18'h0FFFF);
      chk("ol enable", {8'h00, open_cur_en}, 24'h00FFFF);
      cmd(6'h00, 18'h000FF);
      open_det = 16'hFFFF;
      ocur_det = 16'h0001;
      wait_clk(20);
      cmd(6'h00, 18'h000FF);
      chk("fault reply", rep[23:0], 24'h80FF01);
      open_det = 16'h0000;
      ocur_det = 16'h0000;
      cmd(6'h00, 18'h000FF);
      cmd(6'h00, 18'h000FF);
      chk("fault gone", rep[23:0], 24'h000000);
      therm_det = 16'h0001;
      wait_clk(20);
      chk("therm", {8'h00, outs}, 24'h0000FE);
      therm_det = 16'h0000;
      wait_clk(20);
      chk("therm latch", {8'h00, outs}, 24'h0000FE);
      cmd(6'h02, 18'h00000);
      ov_det = 1'b1;
      wait_clk(10100);
      chk("ov shut", {8'h00, outs}, 24'h000000);
      chk("ov flag", {23'h0, ov_shut}, 24'h000001);
      ov_det = 1'b0;
      wait_clk(20);
      chk("ov stay off", {8'h00, outs}, 24'h000000);
      cmd(6'h02, 18'h10000);
      chk("ov reply", rep[23:0], 24'hC00000);
      cmd(6'h00, 18'h0F0F0);
      ov_det = 1'b1;
      wait_clk(10100);
      ov_det = 1'b0;
      wait_clk(20);
      chk("ov restore", {8'h00, outs}, 24'h00F0F0);
      for (int k = 3; k < 6; k++)
         cmd(6'(k), 18'h01230 + 18'(k));
      chk("sfpd", {8'h00, sfpd_r}, 24'h001233);
      chk("pwm", {8'h00, pwm_en_r}, 24'h001234);
      chk("andor", {8'h00, and_or_r}, 24'h001235);
      cmd(6'h06, 18'h00000);
      chk("reset cmd", {8'h00, outs | pwm_en_r}, 24'h000000);
      cmd(6'h00, 18'h0FFFF);
      sop_ok = 1'b0;
      wait_clk(20);
      chk("supply low", {8'h00, outs}, 24'h000000);
      sop_ok = 1'b1;
      wait_clk(20);
      end_sim;
   end
endmodule
